// >>> bench/smbs_ctrl_model.sv
// controller model that issues commands to the sequencer
`timescale 1ns/1ps
module smbs_ctrl_model
(
    input  wire logic        CLK,   // system clock
    output logic             CS_N,  // chip select, active low
    output logic             RAS_N, // row strobe, active low
    output logic             CAS_N, // column strobe, active low
    output logic             WE_N,  // write enable, active low
    output logic      [12:0] ADDR   // address lines
);
    // ****************************************
    // command driver
    // ****************************************
    // deselected until the first command
    initial
        {CS_N, RAS_N, CAS_N, WE_N, ADDR} = 17'h1e000;
    // one command, changed on the falling edge, then a selected nop
    task automatic issue(input logic sel_n, input logic [2:0] code, input logic [11:0] w);
        @(negedge CLK);
        {CS_N, RAS_N, CAS_N, WE_N} = {sel_n, code};
        ADDR = {1'b0, w};
        @(negedge CLK);
        {CS_N, RAS_N, CAS_N, WE_N} = 4'h7;
        ADDR = ~ADDR; // stale address must not stay on the lines
    endtask : issue
endmodule : smbs_ctrl_model

// >>> bench/smbs_sequencer_tb.sv
// self-checking bench for the mode and burst sequencer
`timescale 1ns/1ps
module smbs_sequencer_tb;
    // ****************************************
    // signals and bookkeeping
    // ****************************************
    logic        CLK, RST_N;       // clock and reset
    logic        CS_N, RAS_N, CAS_N, WE_N;
    logic [12:0] ADDR;             // address from the model
    logic [9:0]  COL_ADDR;         // column under access
    logic        COL_VALID, COL_WRITE, DQ_OE, DQ_VALID, NORMAL_MODE;
    logic [11:0] CFG_WORD;         // stored word
    logic [10:0] exp_q[$];         // expected {write, column}
    int          err_count, num_checks, oe_at, dv_at;
    logic        drain;            // extra accesses allowed before a stop ends the burst
    logic [31:0] lfsr_reg;         // random start columns
    smbs_ctrl_model ctrl (.CLK(CLK), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N),
        .WE_N(WE_N), .ADDR(ADDR));
    smbs_sequencer dut (.CLK(CLK), .RST_N(RST_N), .CS_N(CS_N), .RAS_N(RAS_N),
        .CAS_N(CAS_N), .WE_N(WE_N), .ADDR(ADDR), .COL_ADDR(COL_ADDR),
        .COL_VALID(COL_VALID), .COL_WRITE(COL_WRITE), .DQ_OE(DQ_OE),
        .DQ_VALID(DQ_VALID), .CFG_WORD(CFG_WORD), .NORMAL_MODE(NORMAL_MODE));
    // 40 MHz clock
    initial
    begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] lfsr_step(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_step
    // column of the k-th access; page bursts never interleave
    function automatic logic [9:0] exp_col(input logic [2:0] bl, input logic ord,
                                           input logic [9:0] st, input int k);
        logic [9:0] msk;
        msk = (bl == smbs_pkg::BL_PAGE) ? 10'h3ff : 10'((1 << bl) - 1);
        if (ord && bl != smbs_pkg::BL_PAGE)
            return (st & ~msk) | ((st ^ 10'(k)) & msk);
        return (st & ~msk) | ((st + 10'(k)) & msk);
    endfunction : exp_col
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask : check
    task automatic results;
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results
    // bounded wait until every expected access has been seen
    task automatic wait_idle;
        int i;
        for (i = 0; i < 1100; i++)
        begin
            @(negedge CLK);
            if (exp_q.size() == 0 && COL_VALID === 1'b0)
                break;
        end
        if (i == 1100)
        begin
            err_count++;
            results();
        end
    endtask : wait_idle
    task automatic mode(input logic [11:0] w);
        wait_idle();
        ctrl.issue(1'b0, smbs_pkg::CMD_MODE, w);
        @(negedge CLK);
        check(CFG_WORD, w);
        check({11'h0, NORMAL_MODE}, 12'h001);
    endtask : mode
    // program the word, note the column order, start the burst
    task automatic run(input logic [2:0] bl, input logic ord, input logic wr,
                       input logic swr, input logic [2:0] lat, input logic [9:0] st);
        int n;
        mode({2'h0, swr, 2'h0, lat, ord, bl});
        n = (wr && swr) ? 1 : ((bl == smbs_pkg::BL_PAGE) ? 4 : (1 << bl));
        for (int k = 0; k < n; k++)
            exp_q.push_back({wr, exp_col(bl, ord, st, k)});
        ctrl.issue(1'b0, wr ? smbs_pkg::CMD_WRITE : smbs_pkg::CMD_READ, {2'h0, st});
    endtask : run
    // ****************************************
    // monitor: oldest note against each access
    // ****************************************
    always @(posedge CLK)
    begin
        #1;
        if (COL_VALID === 1'b1)
        begin
            if (exp_q.size() > 0)
                check({1'b0, COL_WRITE, COL_ADDR}, {1'b0, exp_q.pop_front()});
            else if (!drain)
                check(12'hfff, 12'h000);
        end
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        {err_count, num_checks, oe_at, dv_at} = '0;
        {RST_N, drain} = 2'b00;
        lfsr_reg = 32'h86c1;
        repeat (6) @(posedge CLK);
        @(negedge CLK) RST_N = 1'b1;
        check(CFG_WORD, smbs_pkg::CFG_RESET);
        for (int b = 0; b < 4; b++)
            for (int o = 0; o < 2; o++)
            begin
                lfsr_reg = lfsr_step(lfsr_reg);
                run(3'(b), 1'(o), 1'b0, 1'b0, smbs_pkg::LAT_2, lfsr_reg[9:0]);
            end
        run(smbs_pkg::BL_8, 1'b1, 1'b0, 1'b0, smbs_pkg::LAT_3, 10'h3fb);
        run(smbs_pkg::BL_4, 1'b0, 1'b1, 1'b0, smbs_pkg::LAT_2, lfsr_reg[19:10]);
        run(smbs_pkg::BL_8, 1'b1, 1'b1, 1'b1, smbs_pkg::LAT_2, lfsr_reg[29:20]);
        run(smbs_pkg::BL_8, 1'b0, 1'b0, 1'b1, smbs_pkg::LAT_2, 10'h1f1);
        // deselected commands during a burst change nothing
        run(smbs_pkg::BL_8, 1'b0, 1'b0, 1'b0, smbs_pkg::LAT_2, 10'h2fd);
        ctrl.issue(1'b1, smbs_pkg::CMD_WRITE, 12'h155);
        ctrl.issue(1'b1, smbs_pkg::CMD_MODE, 12'h0a5);
        wait_idle();
        check(CFG_WORD, 12'h023);
        // full page wraps past the last column, then a stop ends it
        run(smbs_pkg::BL_PAGE, 1'b0, 1'b0, 1'b0, smbs_pkg::LAT_2, 10'h3fe);
        repeat (3) @(negedge CLK);
        drain = 1'b1;
        ctrl.issue(1'b0, smbs_pkg::CMD_STOP, 12'h000);
        repeat (3) @(posedge CLK);
        #1;
        check({11'h0, COL_VALID}, 12'h000);
        check(12'(exp_q.size()), 12'h000);
        drain = 1'b0;
        // first data timing for both latencies
        for (int m = 2; m < 4; m++)
        begin
            run(smbs_pkg::BL_1, 1'b1, 1'b0, 1'b0, 3'(m), lfsr_reg[9:0]);
            {oe_at, dv_at} = '0;
            for (int i = 1; i < 5; i++)
            begin
                @(posedge CLK);
                #1;
                if (DQ_OE === 1'b1 && oe_at == 0)
                    oe_at = i;
                if (DQ_VALID === 1'b1 && dv_at == 0)
                    dv_at = i;
            end
            check(12'(oe_at), 12'(m - 1));
            check(12'(dv_at), 12'(m));
        end
        wait_idle();
        results();
    end
endmodule : smbs_sequencer_tb

// >>> shared/smbs_pkg.sv
// package of constants for the mode and burst sequencer
package smbs_pkg;
    // ********************************************************
    // configuration word layout
    // ********************************************************
    localparam int CFG_W        = 12;              // width of configuration word
    localparam int BL_LSB       = 0;               // burst length field low bit
    localparam int ORDER_BIT    = 3;               // burst order bit
    localparam int LAT_LSB      = 4;               // read latency field low bit
    localparam int OPM_LSB      = 7;               // op mode low bit position
    localparam int SWR_BIT      = 9;               // single write select position
    localparam logic [11:0] CFG_RESET = 12'h000;   // word is unknown at power-up; zero chosen
    // ********************************************************
    // encodings
    // ********************************************************
    localparam logic [2:0] BL_1    = 3'h0;         // burst of one
    localparam logic [2:0] BL_2    = 3'h1;         // burst of two
    localparam logic [2:0] BL_4    = 3'h2;         // burst of four
    localparam logic [2:0] BL_8    = 3'h3;         // burst of eight
    localparam logic [2:0] BL_PAGE = 3'h7;         // full page
    localparam logic [2:0] LAT_2   = 3'h2;         // read latency two
    localparam logic [2:0] LAT_3   = 3'h3;         // read latency three
    localparam int COL_W           = 10;           // column address width
    localparam logic [10:0] PAGE_LEN = 11'h400;    // 1,024 columns per row
    // ********************************************************
    // command codes {ras_n, cas_n, we_n} with chip select low
    // ********************************************************
    localparam logic [2:0] CMD_MODE  = 3'h0;       // mode set
    localparam logic [2:0] CMD_READ  = 3'h5;       // read
    localparam logic [2:0] CMD_WRITE = 3'h4;       // write
    localparam logic [2:0] CMD_STOP  = 3'h6;       // burst stop
endpackage : smbs_pkg

// >>> verilog/smbs_sequencer.sv
// mode register, burst column sequencer and read latency timing
//
// Behaviour
// RL1 - configuration held until next mode set
// RL2 - decode length, order, latency, mode, write
// RL3 - controller drives address twelve low
// RL4 - mode set only when banks idle
// RL5 - lengths 1,2,4,8 and sequential full page
// RL6 - full page runs until burst stop
// RL7 - wrap inside aligned block of length
// RL8 - full page wraps over 1,024 columns
// RL9 - sequential offset is start plus k
// RL10 - interleaved offset is start xor k
// RL11 - length one uses all bits, ignores order
// RL12 - drive at n+m-1, data valid n+m
// RL13 - controller picks latency for frequency
// RL14 - zero op mode is normal operation
// RL15 - single write select makes writes single
// RL16 - controller avoids reserved encodings
// RL17 - deselected: no new commands, bursts continue
// RL18 - mode set: strobes low, word on address
// RL19 - chip select high means deselect
`timescale 1ns/1ps
module smbs_sequencer
(
    input  wire logic        CLK,          // system clock, 40 MHz
    input  wire logic        RST_N,        // asynchronous reset, active low
    input  wire logic        CS_N,         // chip select, active low
    input  wire logic        RAS_N,        // row strobe, active low
    input  wire logic        CAS_N,        // column strobe, active low
    input  wire logic        WE_N,         // write enable, active low
    input  wire logic [12:0] ADDR,         // address; bit 12 ignored
    output logic      [9:0]  COL_ADDR,     // column being accessed
    output logic             COL_VALID,    // column access this cycle
    output logic             COL_WRITE,    // access is a write
    output logic             DQ_OE,        // data outputs driving
    output logic             DQ_VALID,     // first/next read data valid
    output logic      [11:0] CFG_WORD,     // stored configuration word
    output logic             NORMAL_MODE   // op mode field is zero
);
    // ********************************************************
    // command decode
    // ********************************************************
    logic        sel;                       // chip selected this edge
    logic        cmd_mode;                  // mode set command
    logic        cmd_read;                  // read command
    logic        cmd_write;                 // write command
    logic        cmd_stop;                  // burst stop command
    // deselect masks every new command, whatever the other pins say
    assign sel       = !CS_N;                                          // RL19
    assign cmd_mode  = sel && ({RAS_N, CAS_N, WE_N} == smbs_pkg::CMD_MODE);  // RL18
    assign cmd_read  = sel && ({RAS_N, CAS_N, WE_N} == smbs_pkg::CMD_READ);  // RL17
    assign cmd_write = sel && ({RAS_N, CAS_N, WE_N} == smbs_pkg::CMD_WRITE); // RL17
    assign cmd_stop  = sel && ({RAS_N, CAS_N, WE_N} == smbs_pkg::CMD_STOP);  // RL6

    // ********************************************************
    // configuration register
    // ********************************************************
    logic [11:0] cfg_reg;                   // burst_and_latency_config
    // bit 12 of the address is dropped: it is undefined in the word
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            cfg_reg <= smbs_pkg::CFG_RESET;
        else if (cmd_mode)
            cfg_reg <= ADDR[11:0];                                     // RL1 RL3
    end

    logic [2:0] burst_length_field;        // length code
    logic       burst_order_bit;           // 1 = interleaved
    logic [2:0] read_latency_field;        // latency code
    logic       single_write_select;       // writes single location
    assign burst_length_field  = cfg_reg[smbs_pkg::BL_LSB +: 3];       // RL2
    assign burst_order_bit     = cfg_reg[smbs_pkg::ORDER_BIT];         // RL2
    assign read_latency_field  = cfg_reg[smbs_pkg::LAT_LSB +: 3];      // RL2
    assign single_write_select = cfg_reg[smbs_pkg::SWR_BIT];           // RL2

    // ********************************************************
    // burst length decode
    // ********************************************************
    // reserved codes fall back to one access; behaviour there is undefined
    function automatic logic [10:0] smbs_len(input logic [2:0] code);
        unique case (code)
            smbs_pkg::BL_2:    smbs_len = 11'h002;
            smbs_pkg::BL_4:    smbs_len = 11'h004;
            smbs_pkg::BL_8:    smbs_len = 11'h008;
            smbs_pkg::BL_PAGE: smbs_len = smbs_pkg::PAGE_LEN;          // RL5 RL8
            default:           smbs_len = 11'h001;                     // RL5 RL16
        endcase
    endfunction : smbs_len

    // ********************************************************
    // burst state
    // ********************************************************
    logic [9:0]  start_reg;                 // starting column
    logic [10:0] k_reg;                     // access index within burst
    logic [10:0] len_reg;                   // length of this burst
    logic        page_reg;                  // burst is full page
    logic        inter_reg;                 // interleaved ordering
    logic        active_reg;                // burst under way
    logic        wr_reg;                    // burst is a write
    logic [10:0] new_len;                   // length for new command
    // a write with single write select set is one location only
    assign new_len = (cmd_write && single_write_select) ? 11'h001      // RL15
                   : smbs_len(burst_length_field);

    // ********************************************************
    // column generation
    // ********************************************************
    function automatic logic [9:0] smbs_col(input logic [9:0] st, input logic [10:0] k,
                                             input logic [10:0] len, input logic il);
        logic [9:0] msk;
        logic [9:0] off;
        msk = 10'h000;
        off = 10'h000;
        msk = len[9:0] - 10'h001;           // page length gives all ones
        if (len == 11'h001)
            smbs_col = st;                                             // RL11
        else
        begin
            if (il)
                off = (st & msk) ^ (k[9:0] & msk);                     // RL10
            else
                off = ((st & msk) + k[9:0]) & msk;                     // RL9 RL7 RL8
            smbs_col = (st & ~msk) | off;                              // RL7
        end
    endfunction : smbs_col

    // new commands start here; running bursts continue while deselected
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            start_reg  <= 10'h000;
            k_reg      <= 11'h000;
            len_reg    <= 11'h001;
            page_reg   <= 1'b0;
            inter_reg  <= 1'b0;
            active_reg <= 1'b0;
            wr_reg     <= 1'b0;
        end
        else if (cmd_read || cmd_write)
        begin
            start_reg  <= ADDR[9:0];
            k_reg      <= 11'h000;
            len_reg    <= new_len;
            page_reg   <= (new_len == smbs_pkg::PAGE_LEN);
            // interleave is not offered for full page bursts
            inter_reg  <= burst_order_bit && (new_len != smbs_pkg::PAGE_LEN); // RL5
            active_reg <= 1'b1;
            wr_reg     <= cmd_write;
        end
        else if (cmd_stop)
            active_reg <= 1'b0;                                        // RL6
        else if (active_reg)
        begin
            if (page_reg)
                k_reg <= 11'((k_reg + 11'h001) & 11'h3ff);             // RL6 RL8
            else if (k_reg + 11'h001 >= len_reg)
                active_reg <= 1'b0;                                    // RL17
            else
                k_reg <= k_reg + 11'h001;
        end
    end

    // column outputs registered one edge after the index
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            COL_ADDR  <= 10'h000;
            COL_VALID <= 1'b0;
            COL_WRITE <= 1'b0;
        end
        else
        begin
            COL_ADDR  <= smbs_col(start_reg, k_reg, len_reg, inter_reg);
            COL_VALID <= active_reg && !cmd_stop;
            COL_WRITE <= wr_reg;
        end
    end

    // ********************************************************
    // read latency pipeline
    // ********************************************************
    logic [2:0] rd_pipe;                    // read-slot history
    logic       rd_slot;                    // read column issued
    assign rd_slot = (cmd_read || (active_reg && !wr_reg && !cmd_stop &&
                     !cmd_write && !(k_reg + 11'h001 >= len_reg && !page_reg)));
    // slot at edge n shows output enable after n+m-1, valid after n+m
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rd_pipe  <= 3'h0;
            DQ_OE    <= 1'b0;
            DQ_VALID <= 1'b0;
        end
        else
        begin
            rd_pipe  <= {rd_pipe[1:0], rd_slot};
            if (read_latency_field == smbs_pkg::LAT_3)
            begin
                DQ_OE    <= rd_pipe[1];                                // RL12
                DQ_VALID <= rd_pipe[2];                                // RL12
            end
            else
            begin
                DQ_OE    <= rd_pipe[0];                                // RL12
                DQ_VALID <= rd_pipe[1];                                // RL12
            end
        end
    end

    // ********************************************************
    // status outputs
    // ********************************************************
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            CFG_WORD    <= smbs_pkg::CFG_RESET;
            NORMAL_MODE <= 1'b1;
        end
        else
        begin
            CFG_WORD    <= cfg_reg;
            NORMAL_MODE <= (cfg_reg[smbs_pkg::OPM_LSB +: 2] == 2'h0);  // RL14
        end
    end

    // ********************************************************
    // checks
    // ********************************************************
    config_hold_a: assert property (@(posedge CLK) disable iff (!RST_N) // RL1
        !cmd_mode |=> $stable(cfg_reg)) else $error("config changed without mode set");
    config_load_a: assert property (@(posedge CLK) disable iff (!RST_N) // RL18
        cmd_mode |=> cfg_reg == $past(ADDR[11:0])) else $error("config not loaded");
    // a deselected edge may load neither the start column nor the word
    deselect_ignore_a: assert property (@(posedge CLK) disable iff (!RST_N) // RL17 RL19
        CS_N |=> $stable(start_reg) && $stable(cfg_reg))
        else $error("command taken deselected");
    single_write_a: assert property (@(posedge CLK) disable iff (!RST_N) // RL15
        cmd_write && single_write_select |=> len_reg == 11'h001) else $error("write not single");
    first_col_a: assert property (@(posedge CLK) disable iff (!RST_N) // RL9
        (cmd_read || cmd_write) |=> ##1 COL_VALID && COL_ADDR == $past(ADDR[9:0], 2))
        else $error("first column wrong");
    latency_two_a: assert property (@(posedge CLK) disable iff (!RST_N) // RL12
        cmd_read && read_latency_field == smbs_pkg::LAT_2 && $stable(cfg_reg)
        |=> ##1 DQ_OE ##1 DQ_VALID) else $error("latency two timing");
    // output enable is seen one edge after n+2, valid data one edge after n+3
    latency_three_a: assert property (@(posedge CLK) disable iff (!RST_N) // RL12
        cmd_read && read_latency_field == smbs_pkg::LAT_3 && !cmd_mode
        |=> !cmd_mode [*2] ##1 DQ_OE ##1 DQ_VALID) else $error("latency three timing");
    stop_ends_a: assert property (@(posedge CLK) disable iff (!RST_N) // RL6
        cmd_stop |=> !active_reg ##1 !COL_VALID) else $error("stop ignored");
    normal_flag_a: assert property (@(posedge CLK) disable iff (!RST_N) // RL14
        ##1 NORMAL_MODE == ($past(cfg_reg[8:7]) == 2'h0)) else $error("mode flag wrong");
endmodule : smbs_sequencer
